// *** rtl/lvds_align_regs.svh ***
/*
  Register offsets, field positions, reset values and timing figures
  of the sample timing controller.
  Assumes it is included by bare name from the design files.
*/
`ifndef LVDS_ALIGN_REGS_SVH
`define LVDS_ALIGN_REGS_SVH

// Register offsets on the serial register port
`define REG_IRQ 5'h01
`define REG_PROBE 5'h04
`define REG_SDCHK 5'h05
`define REG_IMODE 5'h06
`define REG_SMODE 5'h08
`define REG_DIV 5'h16

// Interrupt register fields
`define IRQ_IN_FLAG 7
`define IRQ_SY_FLAG 6
`define IRQ_IN_EN 3
`define IRQ_SY_EN 2

// Probe register fields
`define PROBE_SETUP_HI 7
`define PROBE_SETUP_LO 4
`define PROBE_HOLD_HI 3
`define PROBE_HOLD_LO 0

// Sample delay register fields
`define SAMP_HI 7
`define SAMP_LO 4
`define CHECK_BIT 0

// Input controller mode fields
`define MODE_WATCH 7
`define MODE_AUTO 6
`define MODE_FLT_HI 5
`define MODE_FLT_LO 2
`define MODE_THR_HI 1
`define MODE_THR_LO 0

// Divider field and base exponent
`define DIV_HI 3
`define DIV_LO 0
`define DIV_BASE 5'h04

// Reset values
`define RST_BYTE 8'h00
`define RST_NIB 4'h0

// Filter figures
`define FLT_MAX 4'hC
`define FRAC_BITS 12
`define PROBE_LAST 4'hF

// Delay step size in ps, realised by the analog delay lines
`define STEP_PS 80

`endif

// *** rtl/lvds_align_pkg.sv ***
/*
  Types shared by the sample timing controller files.
  Assumes nothing of its surroundings.
*/
package lvds_align_pkg;

  // Eye search sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SETUP = 3'h1,
    ST_HOLD = 3'h2,
    ST_EVAL = 3'h3,
    ST_HALT = 3'h4
  } seq_state_t;

endpackage

// *** rtl/ctrl_tick_if.sv ***
/*
  Carrier between the controller and its clock divider.
  Assumes one clock domain; the tick is a one-cycle enable.
*/
`timescale 1ns/1ps
interface ctrl_tick_if;
  logic [3:0] div; // Divider exponent field
  logic tick; // One pulse per controller clock period

  // Divider side
  modport src (input div, output tick);
  // Controller side
  modport sink (output div, input tick);
endinterface

// *** rtl/ctrl_tick_gen.sv ***
/*
  Controller clock divider: one tick every 2^(div+4) converter cycles.
  Assumes clk is the converter clock and ce freezes the count.
*/
`timescale 1ns/1ps
`include "lvds_align_regs.svh"
module ctrl_tick_gen #(
  parameter int CW = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Divider carrier
  ctrl_tick_if.src tk
);

  logic [CW-1:0] cnt_r; // Cycles within the current period
  logic [CW-1:0] last; // Final count of the period

  // Period length minus one, from the divider exponent
  always_comb begin
    last = (CW'(1) << (5'(tk.div) + `DIV_BASE)) - CW'(1);
  end

  // Free running period counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (ce) begin
      if (cnt_r >= last) begin
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_r + CW'(1);
      end
    end
  end

  // Tick marks the last cycle of each period
  assign tk.tick = ce && (cnt_r >= last);

endmodule

// *** rtl/lvds_sample_timing_controller.sv ***
/*
  Data eye alignment controller for the double-rate sample bus input:
  register port, probe and sample delay settings, check bit, eye search
  sequencer with averaging filter, modes and interrupt logic.
  Assumes the analog delay lines sit outside and that every input is
  synchronous to clk; probe_sample is the strobe's look at the clock copy.
*/
`timescale 1ns/1ps
`include "lvds_align_regs.svh"
module lvds_sample_timing_controller #(
  parameter int BUS_W = 14,
  parameter int DIV_CW = 20
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Register port
  input wire logic reg_sel,
  input wire logic reg_we,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Sample bus and converter side
  input wire logic [BUS_W-1:0] sample_bus,
  input wire logic data_sample_strobe,
  output logic [BUS_W-1:0] converter_word,
  // Delay line settings and probe result
  input wire logic probe_sample,
  output logic [3:0] sample_delay,
  output logic [3:0] setup_probe_delay,
  output logic [3:0] hold_probe_delay,
  // Sync controller hooks
  input wire logic sync_alarm,
  output logic [7:0] sync_mode,
  // Interrupt request
  output logic irq
);

  localparam int FW = 18; // Filter word width

  ctrl_tick_if tk (); // Divider carrier
  logic tick; // Controller clock enable

  // Registers
  logic [3:0] div_exp_r; // Divider exponent
  logic [7:0] probe_r; // Manual probe delays
  logic [3:0] samp_dly_r; // Sample delay
  logic check_r; // Check bit
  logic [7:0] imode_r; // Input controller mode
  logic [7:0] smode_r; // Sync controller mode
  logic en_in_r, en_sy_r; // Interrupt enables
  logic flag_in_r, flag_sy_r; // Interrupt flags
  logic low_in_r, low_sy_r; // Enable low for a full period

  // Sequencer
  lvds_align_pkg::seq_state_t st_r; // Eye search state
  logic [3:0] pc_r; // Probe count under test
  logic [3:0] setup_cnt_r, hold_cnt_r; // Measured setup and hold counts
  logic signed [FW-1:0] avg_r; // Filtered eye offset, fixed point

  // Capture pair
  logic [BUS_W-1:0] word_a_r, word_b_r; // Last two captured words
  logic pick_r; // Which word goes out

  // Decoded controls
  logic wr, watch, auto_md;
  logic [3:0] flt_eff;
  logic signed [5:0] diff;
  logic signed [FW-1:0] err_fx, avg_nxt, mag, thr_fx, rnd;
  logic signed [5:0] corr;
  logic signed [6:0] samp_dly_sum;
  logic [3:0] samp_dly_nxt;
  logic exceed;

  assign tk.div = div_exp_r;
  assign tick = tk.tick;

  // Controller clock divider
  ctrl_tick_gen #(.CW(DIV_CW)) u_div (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .tk(tk.src)
  );

  // Mode decode
  always_comb begin
    wr = ce && reg_sel && reg_we;
    watch = imode_r[`MODE_WATCH];
    auto_md = watch && imode_r[`MODE_AUTO];
    flt_eff = imode_r[`MODE_FLT_HI:`MODE_FLT_LO];
    if (flt_eff > `FLT_MAX) begin
      flt_eff = `FLT_MAX;
    end
  end

  // Averaging filter and threshold test on the fresh measurement
  always_comb begin
    diff = $signed({2'b00, hold_cnt_r}) - $signed({2'b00, setup_cnt_r});
    err_fx = $signed({{(FW-6){diff[5]}}, diff}) <<< (`FRAC_BITS - 1);
    avg_nxt = avg_r + ((err_fx - avg_r) >>> flt_eff);
    mag = avg_nxt[FW-1] ? -avg_nxt : avg_nxt;
    thr_fx = $signed(FW'(imode_r[`MODE_THR_HI:`MODE_THR_LO])
      << `FRAC_BITS);
    exceed = mag > thr_fx;
    rnd = (avg_nxt + $signed(FW'(1) << (`FRAC_BITS - 1))) >>> `FRAC_BITS;
    corr = rnd[5:0];
    samp_dly_sum = $signed({3'b000, samp_dly_r}) + $signed({corr[5], corr});
    if (samp_dly_sum < 0) begin
      samp_dly_nxt = `RST_NIB;
    end else if (samp_dly_sum > $signed({3'b000, `PROBE_LAST})) begin
      samp_dly_nxt = `PROBE_LAST;
    end else begin
      samp_dly_nxt = samp_dly_sum[3:0];
    end
  end

  // Host configuration registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_exp_r <= `RST_NIB;
      probe_r <= `RST_BYTE;
      imode_r <= `RST_BYTE;
      smode_r <= `RST_BYTE;
      en_in_r <= 1'b0;
      en_sy_r <= 1'b0;
    end else if (wr) begin
      unique case (reg_addr)
        `REG_DIV: div_exp_r <= reg_wdata[`DIV_HI:`DIV_LO];
        `REG_PROBE: probe_r <= reg_wdata;
        `REG_IMODE: imode_r <= reg_wdata;
        `REG_SMODE: smode_r <= reg_wdata;
        `REG_IRQ: begin
          en_in_r <= reg_wdata[`IRQ_IN_EN];
          en_sy_r <= reg_wdata[`IRQ_SY_EN];
        end
        default: begin
          // Unmapped offsets, and the sample delay offset written in its own block
        end
      endcase
    end
  end

  // Sample delay: host writes, auto mode loads its correction
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      samp_dly_r <= `RST_NIB;
    end else if (wr && reg_addr == `REG_SDCHK) begin
      samp_dly_r <= reg_wdata[`SAMP_HI:`SAMP_LO];
    end else if (tick && st_r == lvds_align_pkg::ST_EVAL && auto_md
                 && exceed) begin
      samp_dly_r <= samp_dly_nxt;
    end
  end

  // Check bit resampled every controller period
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      check_r <= 1'b0;
    end else if (tick) begin
      check_r <= probe_sample;
    end
  end

  // Eye search sequencer, active only in watch or auto mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= lvds_align_pkg::ST_IDLE;
      pc_r <= `RST_NIB;
      setup_cnt_r <= `RST_NIB;
      hold_cnt_r <= `RST_NIB;
      avg_r <= '0;
    end else if (tick) begin
      if (!watch) begin
        st_r <= lvds_align_pkg::ST_IDLE;
        pc_r <= `RST_NIB;
        avg_r <= '0;
      end else begin
        unique case (st_r)
          lvds_align_pkg::ST_IDLE: begin
            st_r <= lvds_align_pkg::ST_SETUP;
            pc_r <= `RST_NIB;
          end
          lvds_align_pkg::ST_SETUP: begin
            // Walk setup probe until the check drops
            if (!probe_sample || pc_r == `PROBE_LAST) begin
              setup_cnt_r <= pc_r;
              pc_r <= `RST_NIB;
              st_r <= lvds_align_pkg::ST_HOLD;
            end else begin
              pc_r <= pc_r + 4'h1;
            end
          end
          lvds_align_pkg::ST_HOLD: begin
            // Walk hold probe until the check drops
            if (!probe_sample || pc_r == `PROBE_LAST) begin
              hold_cnt_r <= pc_r;
              pc_r <= `RST_NIB;
              st_r <= lvds_align_pkg::ST_EVAL;
            end else begin
              pc_r <= pc_r + 4'h1;
            end
          end
          lvds_align_pkg::ST_EVAL: begin
            if (exceed && auto_md) begin
              avg_r <= '0;
              st_r <= lvds_align_pkg::ST_SETUP;
            end else if (exceed) begin
              avg_r <= avg_nxt;
              st_r <= lvds_align_pkg::ST_HALT;
            end else begin
              avg_r <= avg_nxt;
              st_r <= lvds_align_pkg::ST_SETUP;
            end
          end
          lvds_align_pkg::ST_HALT: begin
            // Stopped until the watch bit is cleared
          end
          default: st_r <= lvds_align_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // Enable held low through a whole controller period
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_in_r <= 1'b0;
      low_sy_r <= 1'b0;
    end else if (ce) begin
      low_in_r <= en_in_r ? 1'b0 : (tick ? 1'b1 : low_in_r);
      low_sy_r <= en_sy_r ? 1'b0 : (tick ? 1'b1 : low_sy_r);
    end
  end

  // Interrupt flags; a new event wins over the clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_in_r <= 1'b0;
      flag_sy_r <= 1'b0;
    end else if (ce) begin
      if (tick && st_r == lvds_align_pkg::ST_EVAL && watch && !auto_md
          && exceed) begin
        flag_in_r <= 1'b1;
      end else if (tick && !en_in_r && low_in_r) begin
        flag_in_r <= 1'b0;
      end
      if (sync_alarm) begin
        flag_sy_r <= 1'b1;
      end else if (tick && !en_sy_r && low_sy_r) begin
        flag_sy_r <= 1'b0;
      end
    end
  end

  // Delay outputs: probes manual from registers, else from the sequencer; sample delay always from its register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      setup_probe_delay <= `RST_NIB;
      hold_probe_delay <= `RST_NIB;
      sample_delay <= `RST_NIB;
      irq <= 1'b0;
    end else if (ce) begin
      sample_delay <= samp_dly_r;
      irq <= (flag_in_r && en_in_r) || (flag_sy_r && en_sy_r);
      if (!watch) begin
        setup_probe_delay <= probe_r[`PROBE_SETUP_HI:`PROBE_SETUP_LO];
        hold_probe_delay <= probe_r[`PROBE_HOLD_HI:`PROBE_HOLD_LO];
      end else begin
        setup_probe_delay <= (st_r == lvds_align_pkg::ST_SETUP) ? pc_r
          : `RST_NIB;
        hold_probe_delay <= (st_r == lvds_align_pkg::ST_HOLD) ? pc_r
          : `RST_NIB;
      end
    end
  end

  // Capture pair; output keeps alternating if the strobe stops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      word_a_r <= '0;
      word_b_r <= '0;
      pick_r <= 1'b0;
      converter_word <= '0;
    end else if (ce) begin
      if (data_sample_strobe) begin
        word_a_r <= word_b_r;
        word_b_r <= sample_bus;
      end
      pick_r <= ~pick_r;
      converter_word <= pick_r ? word_b_r : word_a_r;
    end
  end

  // Register read port, data one cycle after the access
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= `RST_BYTE;
      reg_rvalid <= 1'b0;
    end else if (ce) begin
      reg_rvalid <= reg_sel && !reg_we;
      if (reg_sel && !reg_we) begin
        unique case (reg_addr)
          `REG_IRQ: reg_rdata <= {flag_in_r, flag_sy_r, 2'b00,
                                  en_in_r, en_sy_r, 2'b00};
          `REG_PROBE: reg_rdata <= probe_r;
          `REG_SDCHK: reg_rdata <= {samp_dly_r, 3'b000, check_r};
          `REG_IMODE: reg_rdata <= imode_r;
          `REG_SMODE: reg_rdata <= smode_r;
          `REG_DIV: reg_rdata <= {4'h0, div_exp_r};
          default: reg_rdata <= `RST_BYTE;
        endcase
      end
    end
  end

  assign sync_mode = smode_r;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic [DIV_CW-1:0] gap_r; // Enabled cycles since the last tick
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gap_r <= '0;
    end else if (ce) begin
      gap_r <= tick ? '0 : gap_r + DIV_CW'(1);
    end
  end

  sequence s_eval_over;
    tick && st_r == lvds_align_pkg::ST_EVAL && exceed;
  endsequence

  a_tick_period: assert property (tick && $past(tick) == 1'b0 |->
    gap_r == (DIV_CW'(1) << (5'(div_exp_r) + `DIV_BASE)) - DIV_CW'(1)
    || $changed(div_exp_r)) else $error("divider period wrong");
  a_manual_hold: assert property (!watch && !(wr && reg_addr ==
    `REG_SDCHK) |=> $stable(samp_dly_r)) else $error("manual delay moved");
  a_watch_halt: assert property (s_eval_over ##0 !auto_md ##0 watch
    |=> st_r == lvds_align_pkg::ST_HALT && flag_in_r)
    else $error("watch mode did not halt");
  a_auto_quiet: assert property (s_eval_over ##0 auto_md
    |=> !$rose(flag_in_r) && st_r == lvds_align_pkg::ST_SETUP)
    else $error("auto mode flagged");
  a_irq_pin: assert property (ce && flag_in_r && en_in_r |=> irq)
    else $error("irq pin not raised");
  a_clear_low: assert property ($fell(flag_in_r) |->
    $past(!en_in_r && low_in_r && tick))
    else $error("flag cleared early");
  a_check_sample: assert property (tick |=>
    check_r == $past(probe_sample)) else $error("check bit not resampled");
  a_probe_manual: assert property (ce && !watch |=>
    setup_probe_delay == $past(probe_r[`PROBE_SETUP_HI:`PROBE_SETUP_LO]))
    else $error("setup probe not applied");
  a_filter_cap: assert property (flt_eff <= `FLT_MAX)
    else $error("filter length above cap");
  a_capture_word: assert property (ce && data_sample_strobe |=>
    word_b_r == $past(sample_bus)) else $error("word not captured");

endmodule

// *** sim/lvds_eye_model.sv ***
/*
  Far-side model: transmitter with the analog delay lines and eye.
  Assumes the bench sets the eye edges in delay steps.
*/
`timescale 1ns/1ps
`include "lvds_align_regs.svh"
module lvds_eye_model (
  // Clock
  input wire logic clk,
  // Delay settings from the block
  input wire logic [3:0] sample_delay,
  input wire logic [3:0] setup_probe_delay,
  input wire logic [3:0] hold_probe_delay,
  // Eye edges in steps
  input wire logic [4:0] lead_steps,
  input wire logic [4:0] trail_steps,
  // Probe result and sample bus
  output logic probe_sample,
  output logic data_sample_strobe,
  output logic [13:0] sample_bus
);
  int pos_ps; // Strobe position in real time

  // Setup probe moves strobe left, hold probe right
  always_comb begin
    pos_ps = int'(sample_delay) - int'(setup_probe_delay);
    pos_ps = (pos_ps + int'(hold_probe_delay)) * `STEP_PS;
    probe_sample = (pos_ps > -int'(lead_steps) * `STEP_PS) &&
      (pos_ps < int'(trail_steps) * `STEP_PS);
  end

  // Bus idle
  initial begin
    data_sample_strobe = 1'h0;
    sample_bus = 14'h0000;
  end

  // One word per strobe; released bus shows the inverse
  task automatic send_word(input logic [13:0] w);
    @(posedge clk);
    #5;
    sample_bus = w;
    data_sample_strobe = 1'h1;
    @(posedge clk);
    #5;
    data_sample_strobe = 1'h0;
    sample_bus = ~w;
  endtask
endmodule

// *** sim/lvds_sample_timing_controller_test.sv ***
/*
  Self-checking bench of the sample timing controller.
  Assumes the eye model and the design files are compiled first.
*/
`timescale 1ns/1ps
module lvds_sample_timing_controller_test;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic ce = 1'h1; // Always running
  logic reg_sel = 1'h0;
  logic reg_we = 1'h0;
  logic [4:0] reg_addr = 5'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic sync_alarm = 1'h0;
  logic [4:0] lead_steps = 5'h00; // Eye closed at start
  logic [4:0] trail_steps = 5'h0A;
  logic [7:0] reg_rdata, sync_mode, rd_val;
  logic reg_rvalid, irq, probe_sample, data_sample_strobe;
  logic [13:0] sample_bus, converter_word;
  logic [3:0] sample_delay, setup_probe_delay, hold_probe_delay;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0; // Free cycle count
  // Register table: offset, write value, read-back
  logic [4:0] a_t [6] = '{5'h04, 5'h05, 5'h16, 5'h08, 5'h06, 5'h01};
  logic [7:0] w_t [6] = '{8'hA5, 8'h71, 8'hF3, 8'h5A, 8'h3C, 8'hFF};
  logic [7:0] e_t [6] = '{8'hA5, 8'h70, 8'h03, 8'h5A, 8'h3C, 8'h0C};

  // Clock and cycle count
  always #25 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  lvds_sample_timing_controller #(.BUS_W(14), .DIV_CW(20))
    u_lvds_sample_timing_controller (.clk(clk), .rst(rst), .ce(ce),
    .reg_sel(reg_sel), .reg_we(reg_we), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .sample_bus(sample_bus), .data_sample_strobe(data_sample_strobe),
    .converter_word(converter_word), .probe_sample(probe_sample),
    .sample_delay(sample_delay), .setup_probe_delay(setup_probe_delay),
    .hold_probe_delay(hold_probe_delay), .sync_alarm(sync_alarm),
    .sync_mode(sync_mode), .irq(irq));

  lvds_eye_model u_lvds_eye_model (.clk(clk), .sample_delay(sample_delay),
    .setup_probe_delay(setup_probe_delay),
    .hold_probe_delay(hold_probe_delay), .lead_steps(lead_steps),
    .trail_steps(trail_steps), .probe_sample(probe_sample),
    .data_sample_strobe(data_sample_strobe), .sample_bus(sample_bus));

  // Verdict and end of run
  task automatic report_and_stop;
    if (error_cnt == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask

  // Single byte write, taken at one edge
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    #5;
    reg_sel = 1'h1;
    reg_we = 1'h1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #5;
    reg_sel = 1'h0;
    reg_we = 1'h0;
  endtask

  // Read; answer registered at the taking edge, sampled 5 ns after it
  task automatic rd(input logic [4:0] a);
    @(posedge clk);
    #5;
    reg_sel = 1'h1;
    reg_addr = a;
    @(posedge clk);
    #5;
    reg_sel = 1'h0;
    rd_val = (reg_rvalid === 1'h1) ? reg_rdata : 8'hEE; // No answer
  endtask

  // Poll check bit for a level, bounded
  task automatic poll_check(input logic v);
    int k;
    k = 0;
    rd(5'h05);
    while (rd_val[0] !== v && k < 200) begin
      rd(5'h05);
      k++;
    end
    chk(16'(rd_val[0]), 16'(v));
  endtask

  // Step one probe until check drops
  task automatic sweep(input logic hold, output int n_drop);
    n_drop = 16;
    for (int n = 0; n < 16; n++) begin
      wr(5'h04, hold ? {4'h0, 4'(n)} : {4'(n), 4'h0});
      wait_cyc(40);
      rd(5'h05);
      if (rd_val[0] === 1'h0) begin
        n_drop = n;
        break;
      end
    end
  endtask

  // Reset values and unmapped offset
  task automatic reset_values;
    logic [4:0] a [7] = '{5'h01, 5'h04, 5'h05, 5'h06, 5'h08, 5'h16, 5'h02};
    foreach (a[i]) begin
      rd(a[i]);
      chk(16'(rd_val), 16'h0000);
    end
    chk(16'(irq), 16'h0000);
  endtask

  // Field layout, read-only bits, separate mode registers
  task automatic reg_access;
    foreach (a_t[i]) wr(a_t[i], w_t[i]);
    wr(5'h02, 8'hFF);
    foreach (a_t[i]) begin
      rd(a_t[i]);
      chk(16'(rd_val), 16'(e_t[i]));
    end
    rd(5'h02);
    chk(16'(rd_val), 16'h0000);
    chk(16'({setup_probe_delay, hold_probe_delay}), 16'h00A5);
    chk(16'(sample_delay), 16'h0007);
    chk(16'(sync_mode), 16'h005A);
    foreach (a_t[i]) wr(a_t[i], 8'h00);
  endtask

  // Host calibration by probe sweeps
  task automatic manual_cal;
    int m;
    int h;
    lead_steps = 5'h03;
    trail_steps = 5'h09;
    sweep(1'h0, m);
    chk(16'(m), 16'h0003);
    sweep(1'h1, h);
    chk(16'(h), 16'h0009);
    wr(5'h05, {4'((h - m) / 2), 4'h0});
    sweep(1'h0, m);
    sweep(1'h1, h);
    chk(16'(m), 16'h0006);
    chk(16'(h), 16'h0006);
    chk(16'(sample_delay), 16'h0003);
  endtask

  // Check bit updates on the divided tick, 64 cycles
  task automatic divider;
    int t0;
    wr(5'h16, 8'h02);
    wr(5'h04, 8'h00);
    poll_check(1'h1);
    wr(5'h04, 8'hF0);
    poll_check(1'h0);
    t0 = cyc;
    wr(5'h04, 8'h00);
    poll_check(1'h1);
    chk(16'(cyc - t0 >= 58 && cyc - t0 <= 136), 16'h0001);
    wr(5'h16, 8'h00);
  endtask

  // Enabled flag drives irq; clear by holding enable low
  task automatic flag_clear;
    wr(5'h01, 8'h04);
    @(posedge clk);
    #5;
    sync_alarm = 1'h1;
    wait_cyc(1);
    sync_alarm = 1'h0;
    wait_cyc(3);
    chk(16'(irq), 16'h0001);
    rd(5'h01);
    chk(16'(rd_val), 16'h0044);
    wr(5'h01, 8'h00);
    wait_cyc(2);
    chk(16'(irq), 16'h0000);
    rd(5'h01);
    chk(16'(rd_val), 16'h0040);
    wait_cyc(40);
    rd(5'h01);
    chk(16'(rd_val), 16'h0000);
  endtask

  // Watch mode: filter, threshold, flag and halt
  task automatic watch_mode;
    logic [7:0] probes;
    wr(5'h05, 8'h00);
    lead_steps = 5'h02;
    trail_steps = 5'h0A;
    wr(5'h01, 8'h08);
    wr(5'h06, 8'hBF);
    wait_cyc(1000);
    chk(16'(irq), 16'h0000);
    wr(5'h06, 8'h83);
    for (int k = 0; k < 1500 && irq !== 1'h1; k++) wait_cyc(1);
    chk(16'(irq), 16'h0001);
    rd(5'h01);
    chk(16'(rd_val), 16'h0088);
    chk(16'(sample_delay), 16'h0000);
    probes = {setup_probe_delay, hold_probe_delay};
    wait_cyc(200);
    chk(16'({setup_probe_delay, hold_probe_delay}), 16'(probes));
    wr(5'h06, 8'h00);
    wr(5'h01, 8'h00);
    wait_cyc(40);
    lead_steps = 5'h04;
    wr(5'h01, 8'h08);
    wr(5'h06, 8'h83);
    wait_cyc(1500);
    chk(16'(irq), 16'h0000);
  endtask

  // Auto mode: delay moves to eye centre, no flag
  task automatic auto_mode;
    wr(5'h06, 8'h00);
    wr(5'h01, 8'h00);
    wait_cyc(40);
    lead_steps = 5'h02;
    wr(5'h05, 8'h00);
    wr(5'h06, 8'hC1);
    wait_cyc(2000);
    chk(16'(sample_delay), 16'h0004);
    rd(5'h05);
    chk(16'(rd_val[7:4]), 16'h0004);
    rd(5'h01);
    chk(16'(rd_val), 16'h0000);
    chk(16'(irq), 16'h0000);
    wr(5'h06, 8'h00);
  endtask

  // Stopped data clock: output alternates last two words
  task automatic capture;
    logic [13:0] w0;
    u_lvds_eye_model.send_word(14'h1234);
    u_lvds_eye_model.send_word(14'h2ABC);
    wait_cyc(2);
    w0 = converter_word;
    chk(16'(w0 === 14'h1234 || w0 === 14'h2ABC), 16'h0001);
    for (int i = 0; i < 4; i++) begin
      wait_cyc(1);
      chk(16'(converter_word), 16'(w0 ^ 14'h1234 ^ 14'h2ABC));
      w0 = converter_word;
    end
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    #5;
    rst = 1'h0;
    reset_values;
    reg_access;
    manual_cal;
    divider;
    flag_clear;
    watch_mode;
    auto_mode;
    capture;
    report_and_stop;
  end

  // Watchdog, about six times the expected run
  initial begin
    #2000000;
    error_cnt++;
    report_and_stop;
  end
endmodule
